// ==== rtl/sdr_ctl_end.sv ====
// sdr_ctl_end: memory controller end of the sdram link
// assumes the device shares mclk_in; one request in flight at a time
`timescale 1ns/1ns
`default_nettype none
module sdr_ctl_end
   import sdr_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   // clock and reset
   input  wire logic              mclk_in,
   input  wire logic              reset_in,
   // link to device
   sdr_link_if.ctl                lnk,
   // access requests
   input  wire logic              req_valid_in,
   input  wire logic              req_write_in,
   input  wire logic              req_bank_in,
   input  wire logic [ROW_W-1:0]  req_row_in,
   input  wire logic [COL_W-1:0]  req_col_in,
   input  wire logic [1:0]        req_mask_in,
   output logic                   req_ack_out,
   // write data
   input  wire logic              wr_valid_in,
   input  wire logic [DATA_W-1:0] wr_data_in,
   output logic                   wr_ready_out,
   // read data
   output logic [DATA_W-1:0]      rd_data_out,
   output logic                   rd_valid_out
);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;
   localparam int WW = 4;
   localparam int RW = $clog2(REF_CYC);
   typedef enum {CS_MODE, CS_IDLE, CS_ACT, CS_XFER, CS_REC} sdr_ctl_st_t;

   sdr_ctl_st_t         st_ff;
   logic [WW-1:0]       wait_ff;
   logic [WW-1:0]       cnt_ff;
   logic [2:0]          cmd_ff;
   logic [ADDR_W-1:0]   addr_ff;
   logic [DATA_W-1:0]   dq_ff;
   logic                dq_oe_n_ff;
   logic [1:0]          mask_ff;
   logic                ack_ff;
   logic                wr_sel_ff;
   logic                bank_ff;
   logic [COL_W-1:0]    col_ff;
   logic [RW-1:0]       ref_cnt_ff;
   logic                ref_due_ff;
   logic                ref_issue;
   logic [DATA_W-1:0]   rd_data_ff;
   logic                rd_valid_ff;
   logic                pop;
   logic                f_valid;
   logic [DATA_W-1:0]   f_data;
   logic [LW-1:0]       f_level;

   sdr_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
      .mclk_in       (mclk_in),
      .reset_in      (reset_in),
      .in_valid_in   (wr_valid_in),
      .in_ready_out  (wr_ready_out),
      .in_data_in    (wr_data_in),
      .out_valid_out (f_valid),
      .out_ready_in  (pop),
      .out_data_out  (f_data),
      .level_out     (f_level)
   );

   assign pop = wr_sel_ff && f_valid &&
                ((st_ff == CS_ACT && wait_ff == '0) ||
                 (st_ff == CS_XFER && cnt_ff < WW'(CTRL_BL - 1)));
   assign ref_issue = st_ff == CS_IDLE && ref_due_ff;

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         st_ff      <= CS_MODE;
         wait_ff    <= WW'(TREC_CYC);
         cnt_ff     <= '0;
         cmd_ff     <= CMD_NOP;
         addr_ff    <= '0;
         dq_ff      <= '0;
         dq_oe_n_ff <= 1'b1;
         mask_ff    <= 2'b00;
         ack_ff     <= 1'b0;
         wr_sel_ff  <= 1'b0;
         bank_ff    <= 1'b0;
         col_ff     <= '0;
      end else begin
         cmd_ff     <= CMD_NOP;
         ack_ff     <= 1'b0;
         dq_oe_n_ff <= 1'b1;
         if (wait_ff != '0) begin
            wait_ff <= wait_ff - WW'(1);
         end
         unique case (st_ff)
            CS_MODE: if (wait_ff == '0) begin
               cmd_ff  <= CMD_MRS;
               addr_ff <= CTRL_MODE;
               wait_ff <= WW'(TREC_CYC);
               st_ff   <= CS_REC;
            end
            CS_IDLE: if (ref_due_ff) begin
               cmd_ff  <= CMD_REF;
               wait_ff <= WW'(TREC_CYC);
               st_ff   <= CS_REC;
            end else if (req_valid_in &&
                         (!req_write_in || f_level >= LW'(CTRL_BL))) begin
               cmd_ff    <= CMD_ACT;
               addr_ff   <= {req_bank_in, req_row_in};
               bank_ff   <= req_bank_in;
               col_ff    <= req_col_in;
               wr_sel_ff <= req_write_in;
               mask_ff   <= req_mask_in;
               ack_ff    <= 1'b1;
               wait_ff   <= WW'(TRCD_CYC - 1);
               st_ff     <= CS_ACT;
            end
            CS_ACT: if (wait_ff == '0) begin
               cmd_ff  <= wr_sel_ff ? CMD_WR : CMD_RD;
               addr_ff <= {bank_ff, 1'b1, 2'b00, col_ff};
               cnt_ff  <= '0;
               st_ff   <= CS_XFER;
               if (wr_sel_ff) begin
                  dq_ff      <= f_data;
                  dq_oe_n_ff <= 1'b0;
               end
            end
            CS_XFER: begin
               cnt_ff <= cnt_ff + WW'(1);
               if (wr_sel_ff && cnt_ff < WW'(CTRL_BL - 1)) begin
                  dq_ff      <= f_data;
                  dq_oe_n_ff <= 1'b0;
               end
               if (cnt_ff == (wr_sel_ff ? WW'(CTRL_BL - 2) : WW'(CTRL_CL + CTRL_BL - 1))) begin
                  wait_ff <= WW'(TREC_CYC);
                  st_ff   <= CS_REC;
               end
            end
            CS_REC: if (wait_ff == '0) begin
               st_ff <= CS_IDLE;
            end
         endcase
      end
   end

   // refresh timer; a new due flag wins over the clear
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         ref_cnt_ff <= '0;
         ref_due_ff <= 1'b0;
      end else if (ref_cnt_ff == RW'(REF_CYC - 1)) begin
         ref_cnt_ff <= '0;
         ref_due_ff <= 1'b1;
      end else begin
         ref_cnt_ff <= ref_cnt_ff + RW'(1);
         if (ref_issue) begin
            ref_due_ff <= 1'b0;
         end
      end
   end

   // capture read words once the latency has passed
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         rd_data_ff  <= '0;
         rd_valid_ff <= 1'b0;
      end else begin
         rd_data_ff  <= lnk.data_bus_16;
         rd_valid_ff <= st_ff == CS_XFER && !wr_sel_ff &&
                        cnt_ff >= WW'(CTRL_CL) &&
                        cnt_ff < WW'(CTRL_CL + CTRL_BL);
      end
   end

   assign lnk.cke             = 1'b1;
   assign lnk.cs_n            = 1'b0;
   assign {lnk.ras_n, lnk.cas_n, lnk.we_n} = cmd_ff;
   assign lnk.addr            = addr_ff;
   assign lnk.lower_byte_mask = mask_ff[0];
   assign lnk.upper_byte_mask = mask_ff[1];
   assign lnk.dq_ctl          = dq_ff;
   assign lnk.dq_ctl_oe_n     = dq_oe_n_ff;
   assign req_ack_out         = ack_ff;
   assign rd_data_out         = rd_data_ff;
   assign rd_valid_out        = rd_valid_ff;
endmodule // sdr_ctl_end
`default_nettype wire

// ==== rtl/sdr_dev_end.sv ====
// sdr_dev_end: two-bank 16-bit synchronous dram, device end of the link
// assumes the controller shares mclk_in and keeps its refresh duty
`timescale 1ns/1ns
`default_nettype none
module sdr_dev_end
   import sdr_pkg::*;
(
   // clock and reset
   input  wire logic          mclk_in,
   input  wire logic          reset_in,
   // link to controller
   sdr_link_if.dev            lnk,
   // status
   output var sdr_pwr_t       pwr_state_out,
   output logic [ADDR_W-1:0]  mode_out,
   output logic [1:0]         bank_open_out
);
   localparam int IDX_W = 1 + ROW_W + COL_W;

   logic                 cke_meta_ff;
   logic                 cke_sync_ff;
   logic                 clk_ok;
   logic                 sel;
   logic [2:0]           cmd;
   logic                 is_act;
   logic                 is_rd;
   logic                 is_wr;
   logic                 is_pre;
   logic                 is_ref;
   logic                 is_bst;
   logic                 is_mrs;
   logic [ADDR_W-1:0]    mode_ff;
   logic [1:0]           open_ff;
   logic [ROW_W-1:0]     row_ff [2];
   logic                 bst_act_ff;
   logic                 bst_wr_ff;
   logic                 bst_bank_ff;
   logic                 bst_ap_ff;
   logic                 bst_full_ff;
   logic [COL_W-1:0]     bst_base_ff;
   logic [COL_W-1:0]     bst_mask_ff;
   logic [COL_W-1:0]     bst_cnt_ff;
   logic [COL_W-1:0]     nxt_mask;
   logic                 new_cmd;
   logic                 stop;
   logic                 acc_en;
   logic                 acc_wr;
   logic                 acc_bank;
   logic [COL_W-1:0]     acc_col;
   logic [IDX_W-1:0]     acc_idx;
   logic                 bst_done;
   logic                 done_ap;
   logic [DATA_W-1:0]    mem [2**IDX_W];
   logic [1:0]           rd_v_ff;
   logic [DATA_W-1:0]    rd_d_ff [2];
   logic [1:0]           rd_m_ff [2];
   logic [DATA_W-1:0]    dq_ff;
   logic [1:0]           dq_oe_n_ff;
   logic                 out_sel;
   sdr_pwr_t             pwr_ff;
   logic                 last_ref_ff;

   function automatic logic [COL_W-1:0] len_mask(input logic [2:0] bl);
      case (bl)
         BL_1:    len_mask = 8'h00;
         BL_2:    len_mask = 8'h01;
         BL_4:    len_mask = 8'h03;
         BL_8:    len_mask = 8'h07;
         BL_PAGE: len_mask = 8'hff;
         default: len_mask = 8'h00;
      endcase
   endfunction

   // clock enable is the only pin not timed to the clock
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         cke_meta_ff <= 1'b0;
         cke_sync_ff <= 1'b0;
      end else begin
         cke_meta_ff <= lnk.cke;
         cke_sync_ff <= cke_meta_ff;
      end
   end

   assign clk_ok = cke_sync_ff;
   assign sel    = clk_ok && !lnk.cs_n;
   assign cmd    = {lnk.ras_n, lnk.cas_n, lnk.we_n};
   assign is_act = sel && cmd == CMD_ACT;
   assign is_rd  = sel && cmd == CMD_RD;
   assign is_wr  = sel && cmd == CMD_WR;
   assign is_pre = sel && cmd == CMD_PRE;
   assign is_ref = sel && cmd == CMD_REF;
   assign is_bst = sel && cmd == CMD_BST;
   assign is_mrs = sel && cmd == CMD_MRS;

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         mode_ff <= MODE_RESET;
      end else if (is_mrs) begin
         mode_ff <= lnk.addr;
      end
   end

   // column access of this cycle, new command or burst continuation
   always_comb begin
      new_cmd  = is_rd || is_wr;
      stop     = is_bst || is_pre;
      acc_en   = new_cmd || (bst_act_ff && clk_ok && !stop);
      acc_wr   = new_cmd ? is_wr : bst_wr_ff;
      acc_bank = new_cmd ? lnk.addr[BANK_BIT] : bst_bank_ff;
      nxt_mask = (is_wr && mode_ff[MODE_WB_BIT]) ? 8'h00 :
                 len_mask(mode_ff[MODE_BL_LSB +: 3]);
      if (new_cmd) begin
         acc_col = lnk.addr[COL_W-1:0];
      end else if (mode_ff[MODE_BT_BIT]) begin
         acc_col = (bst_base_ff & ~bst_mask_ff) |
                   ((bst_base_ff ^ bst_cnt_ff) & bst_mask_ff);
      end else begin
         acc_col = (bst_base_ff & ~bst_mask_ff) |
                   (COL_W'(bst_base_ff + bst_cnt_ff) & bst_mask_ff);
      end
      bst_done = new_cmd ? (nxt_mask == 8'h00) :
                 (acc_en && bst_cnt_ff == bst_mask_ff && !bst_full_ff);
      done_ap  = new_cmd ? lnk.addr[PMODE_BIT] : bst_ap_ff;
   end

   assign acc_idx = {acc_bank, row_ff[acc_bank], acc_col};

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         bst_act_ff  <= 1'b0;
         bst_wr_ff   <= 1'b0;
         bst_bank_ff <= 1'b0;
         bst_ap_ff   <= 1'b0;
         bst_full_ff <= 1'b0;
         bst_base_ff <= '0;
         bst_mask_ff <= '0;
         bst_cnt_ff  <= '0;
      end else if (new_cmd) begin
         bst_act_ff  <= nxt_mask != 8'h00;
         bst_wr_ff   <= is_wr;
         bst_bank_ff <= lnk.addr[BANK_BIT];
         bst_ap_ff   <= lnk.addr[PMODE_BIT];
         bst_full_ff <= nxt_mask == len_mask(BL_PAGE);
         bst_base_ff <= lnk.addr[COL_W-1:0];
         bst_mask_ff <= nxt_mask;
         bst_cnt_ff  <= 8'h01;
      end else if (stop) begin
         bst_act_ff  <= 1'b0;
      end else if (acc_en) begin
         bst_cnt_ff  <= bst_cnt_ff + 8'h01;
         if (bst_done) begin
            bst_act_ff <= 1'b0;
         end
      end
   end

   // each bank keeps its own open row
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         open_ff <= 2'b00;
         row_ff  <= '{default: '0};
      end else begin
         if (is_act) begin
            open_ff[lnk.addr[BANK_BIT]] <= 1'b1;
            row_ff[lnk.addr[BANK_BIT]]  <= lnk.addr[ROW_W-1:0];
         end
         if (is_pre && lnk.addr[PMODE_BIT]) begin
            open_ff <= 2'b00;
         end else if (is_pre) begin
            open_ff[lnk.addr[BANK_BIT]] <= 1'b0;
         end
         if (bst_done && done_ap) begin
            open_ff[acc_bank] <= 1'b0;
         end
      end
   end

   // storage, byte lanes written separately
   always_ff @(posedge mclk_in) begin
      if (acc_en && acc_wr) begin
         if (!lnk.lower_byte_mask) begin
            mem[acc_idx][7:0] <= lnk.data_bus_16[7:0];
         end
         if (!lnk.upper_byte_mask) begin
            mem[acc_idx][15:8] <= lnk.data_bus_16[15:8];
         end
      end
   end

   // read pipeline, frozen while the clock is suspended
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         rd_v_ff <= 2'b00;
         rd_d_ff <= '{default: '0};
         rd_m_ff <= '{default: '0};
      end else if (clk_ok) begin
         rd_v_ff    <= {rd_v_ff[0], acc_en && !acc_wr};
         rd_d_ff[0] <= mem[acc_idx];
         rd_d_ff[1] <= rd_d_ff[0];
         rd_m_ff[0] <= {lnk.upper_byte_mask, lnk.lower_byte_mask};
         rd_m_ff[1] <= rd_m_ff[0];
      end
   end

   assign out_sel = mode_ff[MODE_CL_LSB +: 3] == CL_3;

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         dq_ff      <= '0;
         dq_oe_n_ff <= 2'b11;
      end else if (clk_ok) begin
         dq_ff      <= rd_d_ff[out_sel];
         dq_oe_n_ff <= ~{2{rd_v_ff[out_sel]}} | rd_m_ff[out_sel];
      end
   end

   assign lnk.dq_dev      = dq_ff;
   assign lnk.dq_dev_oe_n = dq_oe_n_ff;

   // low-power state chosen by what was going on when the clock stopped
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         pwr_ff      <= PWR_RUN;
         last_ref_ff <= 1'b0;
      end else if (clk_ok) begin
         pwr_ff <= PWR_RUN;
         if (sel && cmd != CMD_NOP) begin
            last_ref_ff <= is_ref;
         end
      end else if (pwr_ff == PWR_RUN) begin
         pwr_ff <= last_ref_ff ? PWR_SELF :
                   bst_act_ff ? PWR_SUSPEND : PWR_DOWN;
      end
   end

   assign pwr_state_out = pwr_ff;
   assign mode_out      = mode_ff;
   assign bank_open_out = open_ff;
endmodule // sdr_dev_end
`default_nettype wire

// ==== rtl/sdr_fifo.sv ====
// sdr_fifo: write data buffer with valid/ready on both sides
// assumes DEPTH is a power of two
`timescale 1ns/1ns
`default_nettype none
module sdr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic                     mclk_in,
   input  wire logic                     reset_in,
   // fill side
   input  wire logic                     in_valid_in,
   output logic                          in_ready_out,
   input  wire logic [WIDTH-1:0]         in_data_in,
   // drain side
   output logic                          out_valid_out,
   input  wire logic                     out_ready_in,
   output logic [WIDTH-1:0]              out_data_out,
   output logic [$clog2(DEPTH):0]        level_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_ff;
   logic [AW-1:0]    rp_ff;
   logic [AW:0]      cnt_ff;
   logic [AW:0]      nxt_cnt;
   logic             ready_ff;
   logic             valid_ff;
   logic             push;
   logic             pop;

   assign push    = in_valid_in && ready_ff;
   assign pop     = out_ready_in && valid_ff;
   assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         wp_ff    <= '0;
         rp_ff    <= '0;
         cnt_ff   <= '0;
         ready_ff <= 1'b1;
         valid_ff <= 1'b0;
      end else begin
         wp_ff    <= wp_ff + AW'(push);
         rp_ff    <= rp_ff + AW'(pop);
         cnt_ff   <= nxt_cnt;
         ready_ff <= nxt_cnt != (AW+1)'(DEPTH);
         valid_ff <= nxt_cnt != '0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (push) begin
         mem[wp_ff] <= in_data_in;
      end
   end

   assign in_ready_out  = ready_ff;
   assign out_valid_out = valid_ff;
   assign out_data_out  = mem[rp_ff];
   assign level_out     = cnt_ff;
endmodule // sdr_fifo
`default_nettype wire

// ==== rtl/sdr_link_if.sv ====
// sdr_link_if: pins between memory controller and sdram device
// assumes both ends run on the same clock; resolves the shared data bus
`timescale 1ns/1ns
`default_nettype none
interface sdr_link_if;
   import sdr_pkg::*;
   logic                cke;
   logic                cs_n;
   logic                ras_n;
   logic                cas_n;
   logic                we_n;
   logic [ADDR_W-1:0]   addr;
   logic                lower_byte_mask;
   logic                upper_byte_mask;
   logic [DATA_W-1:0]   dq_ctl;
   logic                dq_ctl_oe_n;
   logic [DATA_W-1:0]   dq_dev;
   logic [1:0]          dq_dev_oe_n;
   logic [DATA_W-1:0]   data_bus_16;

   // device byte wins, then controller, undriven reads zero
   assign data_bus_16[7:0]  = !dq_dev_oe_n[0] ? dq_dev[7:0] :
                              !dq_ctl_oe_n ? dq_ctl[7:0] : 8'h00;
   assign data_bus_16[15:8] = !dq_dev_oe_n[1] ? dq_dev[15:8] :
                              !dq_ctl_oe_n ? dq_ctl[15:8] : 8'h00;

   modport ctl (output cke, cs_n, ras_n, cas_n, we_n, addr, lower_byte_mask,
                upper_byte_mask, dq_ctl, dq_ctl_oe_n, input data_bus_16);
   modport dev (input cke, cs_n, ras_n, cas_n, we_n, addr, lower_byte_mask,
                upper_byte_mask, data_bus_16, output dq_dev, dq_dev_oe_n);
endinterface
`default_nettype wire

// ==== rtl/sdr_pkg.sv ====
// sdr_pkg: shared constants for the two-bank sdram link
// assumes one 50 MHz clock shared by both ends of the link
package sdr_pkg;
   localparam int ADDR_W    = 12;
   localparam int ROW_W     = 11;
   localparam int COL_W     = 8;
   localparam int DATA_W    = 16;
   localparam int PMODE_BIT = 10;
   localparam int BANK_BIT  = 11;

   // command codes as {row strobe, column strobe, write enable}, all active low
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_WR  = 3'h4;
   localparam logic [2:0] CMD_RD  = 3'h5;
   localparam logic [2:0] CMD_BST = 3'h6;
   localparam logic [2:0] CMD_NOP = 3'h7;

   // mode setting code fields
   localparam int MODE_BL_LSB = 0;
   localparam int MODE_BT_BIT = 3;
   localparam int MODE_CL_LSB = 4;
   localparam int MODE_WB_BIT = 9;
   localparam logic [2:0] BL_1    = 3'h0;
   localparam logic [2:0] BL_2    = 3'h1;
   localparam logic [2:0] BL_4    = 3'h2;
   localparam logic [2:0] BL_8    = 3'h3;
   localparam logic [2:0] BL_PAGE = 3'h7;
   localparam logic [2:0] CL_3    = 3'h3;
   localparam logic [ADDR_W-1:0] MODE_RESET = 12'h0020;

   // controller operating point
   localparam int CTRL_CL = 2;
   localparam int CTRL_BL = 4;
   localparam logic [ADDR_W-1:0] CTRL_MODE =
      ADDR_W'((CTRL_CL << MODE_CL_LSB) | (int'(BL_4) << MODE_BL_LSB));

   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int REF_WINDOW_MS = 64;
   localparam int REF_ROWS      = 4096;
   localparam int REF_CYC  = (REF_WINDOW_MS * 1000000) / (REF_ROWS * CLK_PERIOD_NS);
   localparam int TRCD_NS  = 20;
   localparam int TRCD_CYC = (TRCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TREC_NS  = 80;
   localparam int TREC_CYC = (TREC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {PWR_RUN, PWR_DOWN, PWR_SUSPEND, PWR_SELF} sdr_pwr_t;
endpackage

// ==== tb/sdr_link_sva.sv ====
// sdr_link_sva: assertions on the pins between both ends
// assumes instantiation beside the link interface, one clock domain
`timescale 1ns/1ns
`default_nettype none
module sdr_link_sva
   import sdr_pkg::*;
(
   // clock and reset
   input wire logic              mclk_in,
   input wire logic              reset_in,
   // link pins
   input wire logic              cke,
   input wire logic              cs_n,
   input wire logic              ras_n,
   input wire logic              cas_n,
   input wire logic              we_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic              lower_byte_mask,
   input wire logic              upper_byte_mask,
   input wire logic              dq_ctl_oe_n,
   input wire logic [1:0]        dq_dev_oe_n
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   logic [2:0] cmd;
   logic [1:0] msk;
   assign cmd = {ras_n, cas_n, we_n};
   assign msk = {upper_byte_mask, lower_byte_mask};
   sequence s_rd_burst;
      (dq_dev_oe_n == $past(msk, 2)) [*4] ##1 (dq_dev_oe_n == 2'b11);
   endsequence
   sequence s_wr_burst;
      !dq_ctl_oe_n [*4] ##1 dq_ctl_oe_n;
   endsequence
   AST_CKE_ON: assert property (cke)
      else $error("clock enable dropped");
   AST_CS_ON: assert property (!cs_n)
      else $error("chip select not held");
   AST_NO_STOP: assert property (cmd != CMD_PRE && cmd != CMD_BST)
      else $error("unexpected stop command");
   AST_MRS_CODE: assert property (cmd == CMD_MRS |-> addr == CTRL_MODE)
      else $error("wrong mode code");
   AST_ACT_COL: assert property (cmd == CMD_ACT |=>
      (cmd == CMD_RD || cmd == CMD_WR) && addr[BANK_BIT] == $past(addr[BANK_BIT]))
      else $error("column command missing or bank changed");
   AST_COL_AP: assert property ((cmd == CMD_RD || cmd == CMD_WR) |->
      addr[PMODE_BIT] && addr[9:COL_W] == 2'b00)
      else $error("column address form wrong");
   AST_RD_DATA: assert property (cmd == CMD_RD |-> ##2 s_rd_burst)
      else $error("read drive window wrong");
   AST_WR_DATA: assert property (cmd == CMD_WR |-> s_wr_burst)
      else $error("write drive window wrong");
   AST_ONE_DRIVER: assert property (dq_ctl_oe_n || dq_dev_oe_n == 2'b11)
      else $error("both ends drive the bus");
endmodule // sdr_link_sva
`default_nettype wire

// ==== tb/sdram_two_bank_cmd_interface_tb.sv ====
// sdram_two_bank_cmd_interface_tb: both link ends joined, checked end to end
// assumes the controller acks one request at a time and reads return 4 words
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
   $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module sdram_two_bank_cmd_interface_tb;
   import sdr_pkg::*;
   logic              mclk_in, reset_in, req_valid_in, req_write_in, req_bank_in;
   logic              wr_valid_in, req_ack_out, wr_ready_out, rd_valid_out;
   logic [ROW_W-1:0]  req_row_in;
   logic [COL_W-1:0]  req_col_in;
   logic [1:0]        req_mask_in, bank_open_out;
   logic [DATA_W-1:0] wr_data_in, rd_data_out;
   logic [DATA_W-1:0] got [4];
   logic [ADDR_W-1:0] mode_out;
   sdr_pwr_t          pwr_state_out;
   int                fails, num_checks;
   sdr_link_if u_sdr_link_if ();
   sdr_dev_end u_sdr_dev_end (.mclk_in(mclk_in), .reset_in(reset_in), .lnk(u_sdr_link_if),
      .pwr_state_out(pwr_state_out), .mode_out(mode_out), .bank_open_out(bank_open_out));
   sdr_ctl_end #(.FIFO_DEPTH(16)) u_sdr_ctl_end (.mclk_in(mclk_in), .reset_in(reset_in),
      .lnk(u_sdr_link_if), .req_valid_in(req_valid_in), .req_write_in(req_write_in),
      .req_bank_in(req_bank_in), .req_row_in(req_row_in), .req_col_in(req_col_in),
      .req_mask_in(req_mask_in), .req_ack_out(req_ack_out), .wr_valid_in(wr_valid_in),
      .wr_data_in(wr_data_in), .wr_ready_out(wr_ready_out), .rd_data_out(rd_data_out),
      .rd_valid_out(rd_valid_out));
   sdr_link_sva u_sdr_link_sva (.mclk_in(mclk_in), .reset_in(reset_in),
      .cke(u_sdr_link_if.cke), .cs_n(u_sdr_link_if.cs_n), .ras_n(u_sdr_link_if.ras_n),
      .cas_n(u_sdr_link_if.cas_n), .we_n(u_sdr_link_if.we_n), .addr(u_sdr_link_if.addr),
      .lower_byte_mask(u_sdr_link_if.lower_byte_mask),
      .upper_byte_mask(u_sdr_link_if.upper_byte_mask),
      .dq_ctl_oe_n(u_sdr_link_if.dq_ctl_oe_n), .dq_dev_oe_n(u_sdr_link_if.dq_dev_oe_n));
   function automatic logic [15:0] d(input int i);
      return 16'ha050 + 16'h0101 * 16'(i);
   endfunction
   task automatic close_out();
      if (fails == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // one request; for reads, gathers the returned words into got
   task automatic req(input logic w, b, input logic [ROW_W-1:0] r,
                      input logic [COL_W-1:0] c, input logic [1:0] m);
      int n;
      n = 0;
      got = '{default: 'x};
      req_valid_in <= 1'b1;
      req_write_in <= w;
      req_bank_in  <= b;
      req_row_in   <= r;
      req_col_in   <= c;
      req_mask_in  <= m;
      repeat (3000) begin
         @(posedge mclk_in);
         if (req_ack_out === 1'b1) break;
      end
      // no acknowledge within the limit counts as a mismatch
      if (req_ack_out !== 1'b1) fails++;
      req_valid_in <= 1'b0;
      // writes let one edge pass so the next call never re-drives valid in this step
      if (w) @(posedge mclk_in);
      else repeat (20) begin
         @(posedge mclk_in);
         if (rd_valid_out === 1'b1 && n < 4) begin
            got[n] = rd_data_out;
            n++;
         end
      end
   endtask
   initial begin
      mclk_in = 1'b0;
      forever #10 mclk_in = ~mclk_in;
   end
   initial begin
      repeat (20000) @(posedge mclk_in);
      fails++;
      close_out();
   end
   initial begin
      {reset_in, req_valid_in, req_write_in, req_bank_in, wr_valid_in} <= 5'h10;
      {req_row_in, req_col_in, req_mask_in, wr_data_in} <= '0;
      repeat (4) @(posedge mclk_in);
      reset_in <= 1'b0;
      // two words beyond the 16 held must be refused
      for (int i = 0; i < 18; i++) begin
         wr_valid_in <= 1'b1;
         wr_data_in  <= d(i);
         @(posedge mclk_in);
      end
      wr_valid_in <= 1'b0;
      `CHK(wr_ready_out, 1'b0)
      `CHK(mode_out, CTRL_MODE)
      req(1, 0, 11'h2c3, 8'h00, 2'b00);
      req(1, 1, 11'h2c3, 8'h00, 2'b00);
      req(1, 0, 11'h2c3, 8'h00, 2'b01);
      // same bank and column, other row: must not disturb the first row
      req(1, 0, 11'h53c, 8'h00, 2'b00);
      req(0, 0, 11'h2c3, 8'h00, 2'b00);
      for (int i = 0; i < 4; i++) `CHK(got[i], (d(8+i) & 16'hff00) | (d(i) & 16'h00ff))
      req(0, 1, 11'h2c3, 8'h00, 2'b00);
      for (int i = 0; i < 4; i++) `CHK(got[i], d(4+i))
      req(0, 0, 11'h53c, 8'h00, 2'b00);
      for (int i = 0; i < 4; i++) `CHK(got[i], d(12+i))
      repeat (1600) @(posedge mclk_in);
      req(0, 0, 11'h2c3, 8'h00, 2'b10);
      for (int i = 0; i < 4; i++) `CHK(got[i], d(i) & 16'h00ff)
      `CHK(bank_open_out, 2'b00)
      `CHK(pwr_state_out, PWR_RUN)
      close_out();
   end
endmodule // sdram_two_bank_cmd_interface_tb
`default_nettype wire
